//--- core/csr_pkg.sv
// Notes on behaviour
// - register holds alu flags, reset-cause bits and the page select bit.
// - any instruction may target this register like any other file register.
// - flag-updating instruction to this register: flags come from result, not data.
// - data writes never touch time-out and power-down bits; only hw events do.
// - clear-file on this register gives 000u u1uu.
// - bit clear, bit set, move-from-w leave flags alone; data lands exactly.
// - power-on: bit7,bit5 zero; bits 4,3 one; bits 2..0 zero; 4,3 read-only.
// - bit 6 has no storage and reads zero.
// - pin wake flag set on pin-change wake reset, cleared on other resets.
// - bit 5 is the page select: one = page 1, zero = page 0.
// - time-out bit set by power-up, wdog clear, sleep; cleared by wdog time-out.
// - power-down bit set by power-up, wdog clear; cleared by sleep.
package csr_pkg;
  // ---------------------------------------------------------------
  // register address and bit positions
  // ---------------------------------------------------------------
  localparam logic [7:0] CSR_OFFSET = 8'h03;
  localparam int CSR_BIT_WAKE = 7;
  localparam int CSR_BIT_PAGE = 5;
  localparam int CSR_BIT_TO = 4;
  localparam int CSR_BIT_PD = 3;
  localparam int CSR_BIT_Z = 2;
  localparam int CSR_BIT_DC = 1;
  localparam int CSR_BIT_C = 0;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic CSR_RST_WAKE = 1'b0;
  localparam logic CSR_RST_PAGE = 1'b0;
  localparam logic CSR_RST_TO = 1'b1;
  localparam logic CSR_RST_PD = 1'b1;
  localparam logic [2:0] CSR_RST_FLAGS = 3'h0;
  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic z;
    logic dc;
    logic c;
  } csr_flags_s;
  typedef struct packed {
    logic wdog_clear_op;
    logic sleep_op;
    logic wdog_timeout;
    logic pin_wake_reset;
    logic other_reset;
  } csr_events_s;
endpackage : csr_pkg

//--- core/csr_flag_bit.sv
`timescale 1ns/1ps
`default_nettype none
// one hardware-owned bit: set beats clear, data never reaches it
module csr_flag_bit #(
  parameter logic RST_VAL = 1'b1
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  // events
  input wire logic i_set,
  input wire logic i_clr,
  // state
  output logic o_q
);
  logic q_q;
  logic q_d;
  assign q_d = i_set ? 1'b1 : (i_clr ? 1'b0 : q_q);
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      q_q <= RST_VAL;
    end else begin
      q_q <= q_d;
    end
  end
  assign o_q = q_q;
endmodule : csr_flag_bit
`default_nettype wire

//--- core/csr_core_status.sv
`timescale 1ns/1ps
`default_nettype none
module csr_core_status (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  // register port (destination write in the write phase)
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // alu flag update for the same instruction
  input wire logic i_flag_upd,
  input wire csr_pkg::csr_flags_s i_flags,
  // hardware events
  input wire csr_pkg::csr_events_s i_evt,
  // live state
  output logic [7:0] o_status,
  output logic o_page_select_bit
);
  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire hit_wr;
  wire hit_rd;
  wire data_wr_flags;
  wire [7:0] cur;
  assign hit_wr = i_wr && (i_addr == csr_pkg::CSR_OFFSET);
  assign hit_rd = i_rd && (i_addr == csr_pkg::CSR_OFFSET);
  // bit ops and move-from-w come without i_flag_upd, so data lands exactly
  assign data_wr_flags = hit_wr && !i_flag_upd;
  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic pin_wake_flag_q;
  logic page_select_bit_q;
  logic [2:0] flags_q;
  logic [2:0] flags_d;
  logic wdog_expired_n;
  logic sleep_entered_n;
  // alu result overrides data; clear-file sends z=1 via i_flags
  assign flags_d = i_flag_upd ? i_flags :
                   (data_wr_flags ? i_wdata[2:0] : flags_q);
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      page_select_bit_q <= csr_pkg::CSR_RST_PAGE;
      flags_q <= csr_pkg::CSR_RST_FLAGS;
    end else begin
      if (hit_wr) begin
        page_select_bit_q <= i_wdata[csr_pkg::CSR_BIT_PAGE];
      end
      flags_q <= flags_d;
    end
  end
  // wake flag: written by data, set by wake reset (set wins), other clears
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pin_wake_flag_q <= csr_pkg::CSR_RST_WAKE;
    end else if (i_evt.pin_wake_reset) begin
      pin_wake_flag_q <= 1'b1;
    end else if (i_evt.other_reset) begin
      pin_wake_flag_q <= 1'b0;
    end else if (hit_wr) begin
      pin_wake_flag_q <= i_wdata[csr_pkg::CSR_BIT_WAKE];
    end
  end
  // time-out and power-down are hardware only; no data path reaches them
  csr_flag_bit #(
    .RST_VAL(csr_pkg::CSR_RST_TO)
  ) u_to (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_set(i_evt.wdog_clear_op || i_evt.sleep_op),
    .i_clr(i_evt.wdog_timeout),
    .o_q(wdog_expired_n)
  );
  csr_flag_bit #(
    .RST_VAL(csr_pkg::CSR_RST_PD)
  ) u_pd (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_set(i_evt.wdog_clear_op),
    .i_clr(i_evt.sleep_op),
    .o_q(sleep_entered_n)
  );
  // ---------------------------------------------------------------
  // read back
  // ---------------------------------------------------------------
  assign cur = {pin_wake_flag_q, 1'b0, page_select_bit_q,
                wdog_expired_n, sleep_entered_n, flags_q};
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= hit_rd ? cur : 8'h00;
    end
  end
  assign o_status = cur;
  assign o_page_select_bit = page_select_bit_q;
endmodule : csr_core_status
`default_nettype wire

//--- bench/csr_core_status_props.sv
`timescale 1ns/1ps
`default_nettype none
module csr_core_status_props (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  // inputs
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_flag_upd,
  input wire csr_pkg::csr_flags_s i_flags,
  input wire csr_pkg::csr_events_s i_evt,
  // outputs
  input wire logic [7:0] o_rdata,
  input wire logic [7:0] o_status,
  input wire logic o_page_select_bit
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  wire hit = i_addr == csr_pkg::CSR_OFFSET;
  a_data_lands: assert property (
    i_wr && hit && !i_flag_upd && i_evt == '0
    |=> (o_status & 8'ha7) == ($past(i_wdata) & 8'ha7)) else $error("data");
  a_alu_wins: assert property (
    i_flag_upd |=> o_status[2:0] == $past(i_flags)) else $error("flags");
  a_ro_bits: assert property (
    i_evt[4:2] == 3'h0 |=> $stable(o_status[4:3])) else $error("ro");
  a_bit6_zero: assert property (
    o_status[6] == 1'b0 && o_rdata[6] == 1'b0) else $error("bit6");
  a_page_out: assert property (
    o_page_select_bit == o_status[5]) else $error("page");
  a_page_write: assert property (
    i_wr && hit |=> o_page_select_bit == $past(i_wdata[5]))
    else $error("page write");
  a_to_clear: assert property (
    i_evt == 5'h04 |=> !o_status[4]) else $error("to");
  a_pd_clear: assert property (
    i_evt == 5'h08 |=> o_status[4:3] == 2'h2) else $error("pd");
  a_wdog_set: assert property (
    i_evt.wdog_clear_op |=> o_status[4:3] == 2'h3) else $error("wdog");
  a_wake_set: assert property (
    i_evt.pin_wake_reset |=> o_status[7]) else $error("wake");
  a_read_data: assert property (
    i_rd && hit |=> o_rdata == $past(o_status)) else $error("read");
endmodule : csr_core_status_props
bind csr_core_status csr_core_status_props u_props (.*);
`default_nettype wire

//--- bench/test_csr_core_status.sv
`timescale 1ns/1ps
`default_nettype none
module test_csr_core_status;
  logic i_clock = 0, i_rst_b = 0, wr = 0, rd = 0, fu = 0, pg;
  logic [7:0] addr = 0, wdata = 0, rdata, st;
  csr_pkg::csr_flags_s fl = '0;
  csr_pkg::csr_events_s ev = '0;
  int err_count = 0, tests_run = 0;
  always #12.5 i_clock = ~i_clock;
  csr_core_status u_csr_core_status (.i_clock(i_clock), .i_rst_b(i_rst_b),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_flag_upd(fu), .i_flags(fl), .i_evt(ev), .o_status(st),
    .o_page_select_bit(pg));
  task automatic chk(input logic [7:0] s, e);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("unexpected at %0t: %h vs %h", $time, s, e);
    end
  endtask : chk
  // one cycle of request, then idle; results settle 1 ns later
  task automatic op(input logic [7:0] a, d, input logic [2:0] w, f,
                    input logic [4:0] e);
    @(posedge i_clock);
    {addr, wdata, wr, rd, fu, fl, ev} <= {a, d, w, f, e};
    @(posedge i_clock);
    {wr, rd, fu, ev} <= '0;
    #1;
  endtask : op
  task automatic t_por;
    op(8'h03, 8'h00, 3'h2, 3'h0, 5'h00);
    chk(rdata, 8'h18);
    chk({7'h0, pg}, 8'h00);
  endtask : t_por
  task automatic t_write;
    op(8'h03, 8'h00, 3'h4, 3'h0, 5'h00);
    chk(st, 8'h18);
    op(8'h03, 8'hff, 3'h4, 3'h0, 5'h00);
    chk(st, 8'hbf);
    chk({7'h0, pg}, 8'h01);
    op(8'h04, 8'h00, 3'h4, 3'h0, 5'h00);
    chk(st, 8'hbf);
    op(8'h04, 8'h00, 3'h2, 3'h0, 5'h00);
    chk(rdata, 8'h00);
  endtask : t_write
  task automatic t_clear_file_op;
    // dc and c fed back as they stand, as an alu leaving them alone
    op(8'h03, 8'h00, 3'h5, 3'h7, 5'h00);
    chk(st, 8'h1f);
    op(8'h03, 8'h02, 3'h4, 3'h0, 5'h00);
    chk(st, 8'h1a);
  endtask : t_clear_file_op
  task automatic t_evt;
    // last three: set and clear together, the set must win
    logic [4:0] e [8] = '{5'h04, 5'h08, 5'h10, 5'h02, 5'h01, 5'h0c,
                          5'h18, 5'h03};
    logic [7:0] x [8] = '{8'h0a, 8'h12, 8'h1a, 8'h9a, 8'h1a, 8'h12,
                          8'h1a, 8'h9a};
    for (int i = 0; i < 8; i++) begin
      op(8'h00, 8'h00, 3'h0, 3'h0, e[i]);
      chk(st, x[i]);
    end
  endtask : t_evt
  // reset in mid-run must bring back the power-on pattern
  task automatic t_reset;
    @(posedge i_clock);
    i_rst_b <= 1'b0;
    @(posedge i_clock);
    #1;
    chk(st, 8'h18);
    chk(rdata, 8'h00);
    @(posedge i_clock);
    i_rst_b <= 1'b1;
  endtask : t_reset
  task automatic print_verdict;
    if (err_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (4) @(posedge i_clock);
    i_rst_b <= 1'b1;
    t_por;
    t_write;
    t_clear_file_op;
    t_evt;
    t_reset;
    t_por;
    print_verdict;
  end
  // about 40 cycles of work; stop well past that
  initial begin
    #20000;
    err_count++;
    print_verdict;
  end
endmodule : test_csr_core_status
`default_nettype wire
